//--- wdt_pkg.sv
// Purpose: shared constants for the watchdog block
// Assumes: 25 mhz system clock, 32.768 khz watchdog count rate
// Notes:   control register is 8 bits wide
package wdt_pkg;

    // ------------------------------------------------------------
    // clocking
    // ------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ   = 25000000;
    localparam int unsigned WDT_TICK_HZ  = 32768;
    localparam int unsigned TICK_DIV     = SYS_CLK_HZ / WDT_TICK_HZ;
    localparam int unsigned DIV_W        = 10;

    // ------------------------------------------------------------
    // control register layout
    // ------------------------------------------------------------
    localparam int unsigned UNLOCK_BIT   = 0;
    localparam int unsigned ENABLE_BIT   = 1;
    localparam int unsigned STATUS_BIT   = 2;
    localparam int unsigned PRE_LSB      = 4;
    localparam int unsigned PRE_W        = 4;
    localparam logic [7:0]  CTL_RESET    = 8'h10;
    localparam logic [3:0]  PRE_RESET    = 4'h1;

    // ------------------------------------------------------------
    // timeout
    // ------------------------------------------------------------
    localparam int unsigned CNT_W        = 16;
    localparam int unsigned BASE_SHIFT   = 9;
    localparam logic [3:0]  PRE_MAX      = 4'h7;
    localparam logic [3:0]  PRE_IMMED    = 4'h8;

endpackage

//--- wdt_tick_div.sv
// Purpose: divides the system clock to the watchdog count rate
// Assumes: single clock domain
// Notes:   emits a one-cycle enable pulse
module wdt_tick_div
(
    input  wire logic mclk_in,
    input  wire logic rst_in,
    output logic      tick_out
);

    logic [wdt_pkg::DIV_W-1:0] div_ff;

    // ------------------------------------------------------------
    // divider
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            div_ff   <= '0;
            tick_out <= 1'b0;
        end
        else if (div_ff == wdt_pkg::DIV_W'(wdt_pkg::TICK_DIV - 1))
        begin
            div_ff   <= '0;
            tick_out <= 1'b1;
        end
        else
        begin
            div_ff   <= div_ff + 1'b1;
            tick_out <= 1'b0;
        end
    end

endmodule

//--- watchdog_timer_control.sv
// Purpose: watchdog timer with protected control register
// Assumes: core presents register writes and instruction retire pulses
// Notes:   timeout drives either a reset request or an interrupt

// Overview of operation
// R1: 16-bit counter, timeout 2^code times 512 ticks
// R2: code 8 immediate reset; above reserved (with timeout_irq_sel_in high, code 8 raises an immediate interrupt instead)
// R3: timeout sets status flag, bit 2
// R4: status cleared by writing zero or reset
// R5: status survives watchdog-caused reset; here any rst_in clears it, whatever its cause
// R6: writing enable one enables and clears counter
// R7: missed refresh raises reset or interrupt
// R8: write accepted only right after unlock
// R9: interrupt is high priority; timer use
// R10: software masks interrupts around unlock sequence
module watchdog_timer_control
(
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic       ctl_wr_in,
    input  wire logic [7:0] ctl_wdata_in,
    input  wire logic       instr_retire_in,
    input  wire logic       timeout_irq_sel_in,
    output logic [7:0]      watchdog_control_out,
    output logic            sys_reset_req_out,
    output logic            wdt_irq_out
);

    logic                   tick;
    logic                   control_write_unlock_ff;
    logic                   watchdog_enable_refresh_ff;
    logic                   timeout_status_flag_ff;
    logic [3:0]             timeout_prescale_code_ff;
    logic [wdt_pkg::CNT_W-1:0] cnt_ff;
    logic                   accept_wr;
    logic                   refresh;
    logic                   timeout;
    logic                   nxt_unlock;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [wdt_pkg::CNT_W-1:0] last_count(input logic [3:0] code);
        logic [wdt_pkg::CNT_W:0] lim;
        lim = (wdt_pkg::CNT_W+1)'(1) << (wdt_pkg::BASE_SHIFT + 32'(code));
        last_count = wdt_pkg::CNT_W'(lim - 1'b1);
    endfunction

    wdt_tick_div u_div
    (
        .mclk_in  (mclk_in),
        .rst_in   (rst_in),
        .tick_out (tick)
    );

    // ------------------------------------------------------------
    // unlock and write acceptance
    // ------------------------------------------------------------
    assign accept_wr = ctl_wr_in && control_write_unlock_ff; // see R8
    assign refresh   = accept_wr && ctl_wdata_in[wdt_pkg::ENABLE_BIT]; // see R6

    always_comb
    begin
        if (ctl_wr_in)
            nxt_unlock = !control_write_unlock_ff && ctl_wdata_in[wdt_pkg::UNLOCK_BIT]; // see R8
        else if (instr_retire_in)
            nxt_unlock = 1'b0; // see R8
        else
            nxt_unlock = control_write_unlock_ff;
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            control_write_unlock_ff <= 1'b0;
        else
            control_write_unlock_ff <= nxt_unlock;
    end

    // ------------------------------------------------------------
    // timeout detection
    // ------------------------------------------------------------
    always_comb
    begin
        if (!watchdog_enable_refresh_ff || refresh)
            timeout = 1'b0;
        else if (timeout_prescale_code_ff == wdt_pkg::PRE_IMMED)
            timeout = 1'b1; // see R2
        else if (timeout_prescale_code_ff > wdt_pkg::PRE_IMMED)
            timeout = 1'b0; // see R2
        else
            timeout = tick && (cnt_ff == last_count(timeout_prescale_code_ff)); // see R1, R7
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            cnt_ff <= '0;
        else if (refresh || timeout || !watchdog_enable_refresh_ff)
            cnt_ff <= '0; // see R6
        else if (tick && timeout_prescale_code_ff <= wdt_pkg::PRE_MAX)
            cnt_ff <= cnt_ff + 1'b1; // see R1
    end

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            watchdog_enable_refresh_ff <= 1'b0;
            timeout_prescale_code_ff   <= wdt_pkg::PRE_RESET;
        end
        else if (accept_wr)
        begin
            watchdog_enable_refresh_ff <= ctl_wdata_in[wdt_pkg::ENABLE_BIT]; // see R6
            timeout_prescale_code_ff   <= ctl_wdata_in[wdt_pkg::PRE_LSB +: wdt_pkg::PRE_W];
        end
        else if (timeout && !timeout_irq_sel_in)
            watchdog_enable_refresh_ff <= 1'b0;
    end

    // ------------------------------------------------------------
    // status flag, cleared only by external reset or a zero write
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            timeout_status_flag_ff <= 1'b0; // see R4
        else if (timeout)
            timeout_status_flag_ff <= 1'b1; // see R3, R5
        else if (accept_wr && !ctl_wdata_in[wdt_pkg::STATUS_BIT])
            timeout_status_flag_ff <= 1'b0; // see R4
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sys_reset_req_out <= 1'b0;
            wdt_irq_out       <= 1'b0;
        end
        else
        begin
            sys_reset_req_out <= timeout && !timeout_irq_sel_in; // see R7
            wdt_irq_out       <= timeout && timeout_irq_sel_in; // see R7, R9
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
            watchdog_control_out <= wdt_pkg::CTL_RESET;
        else
            watchdog_control_out <= {timeout_prescale_code_ff,
                                     1'b0,
                                     timeout_status_flag_ff,
                                     watchdog_enable_refresh_ff,
                                     control_write_unlock_ff};
    end

endmodule

//--- wdt_chk.sv
// Purpose: port assertions for the watchdog block
// Assumes: readback lags state by one cycle
// Notes:   fast prescale codes only
module wdt_chk
(
    input  wire logic       mclk_in,
    input  wire logic       rst_in,
    input  wire logic       ctl_wr_in,
    input  wire logic [7:0] ctl_wdata_in,
    input  wire logic       timeout_irq_sel_in,
    input  wire logic [7:0] watchdog_control_out,
    input  wire logic       sys_reset_req_out,
    input  wire logic       wdt_irq_out
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    sequence armed;
        watchdog_control_out[1] && watchdog_control_out[7:4] == 4'h8;
    endsequence
    sequence wr_two_ago;
        $past(ctl_wr_in, 2);
    endsequence
    one_req_a: assert property (sys_reset_req_out |=> !sys_reset_req_out)
        else $error("reset request too long");
    one_kind_a: assert property (!(sys_reset_req_out && wdt_irq_out))
        else $error("both outputs at once");
    status_set_a: assert property (sys_reset_req_out || wdt_irq_out |=> watchdog_control_out[2])
        else $error("status not set");
    status_keep_a: assert property ($fell(watchdog_control_out[2]) |->
        $past(ctl_wr_in, 2) && !$past(ctl_wdata_in[2], 2)) else $error("status lost");
    pre_lock_a: assert property ($changed(watchdog_control_out[7:4]) |->
        wr_two_ago ##0 $past(watchdog_control_out[0])) else $error("locked field changed");
    enable_set_a: assert property ($rose(watchdog_control_out[1]) |->
        wr_two_ago ##0 $past(ctl_wdata_in[1], 2)) else $error("enable without write");
    immed_reset_a: assert property (armed ##0 !timeout_irq_sel_in |->
        ##[0:2] sys_reset_req_out) else $error("no immediate reset");
    immed_irq_a: assert property (armed ##0 timeout_irq_sel_in |->
        ##[0:2] wdt_irq_out) else $error("no interrupt");
    quiet_a: assert property (sys_reset_req_out || wdt_irq_out |->
        watchdog_control_out[1] || $past(watchdog_control_out[1]))
        else $error("timeout while disabled");
endmodule
bind watchdog_timer_control wdt_chk u_chk (.*);

//--- testbench.sv
// Purpose: self-checking bench for the watchdog block
// Assumes: fast prescale codes only
// Notes:   long timeouts are out of reach
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic u; logic [7:0] d; logic [7:0] e;} row_t;
    logic       mclk_in = 1'b0;
    logic       rst_in  = 1'b1;
    logic       wr      = 1'b0;
    logic [7:0] wd      = 8'h00;
    logic       ret     = 1'b0;
    logic       sel     = 1'b0;
    logic [7:0] ctl;
    logic       req;
    logic       irq;
    int         fails   = 0;
    int         checks  = 0;
    int         nreq;
    int         nirq;
    row_t       rows [6] = '{'{1'b0, 8'h72, 8'h10}, '{1'b1, 8'h72, 8'h72},
        '{1'b1, 8'h30, 8'h30}, '{1'b0, 8'h01, 8'h31}, '{1'b0, 8'h92, 8'h92},
        '{1'b1, 8'h00, 8'h00}};
    watchdog_timer_control u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .ctl_wr_in(wr),
        .ctl_wdata_in(wd), .instr_retire_in(ret), .timeout_irq_sel_in(sel),
        .watchdog_control_out(ctl), .sys_reset_req_out(req), .wdt_irq_out(irq));
    task automatic w(input logic [7:0] d);
        wr = 1'b1;
        wd = d;
        @(posedge mclk_in);
        #1;
    endtask
    task automatic idle();
        wr = 1'b0;
        repeat (2) @(posedge mclk_in);
        #1;
    endtask
    task automatic run(input int n);
        nreq = 0;
        nirq = 0;
        repeat (n)
        begin
            @(posedge mclk_in);
            #1;
            nreq += int'(req === 1'b1);
            nirq += int'(irq === 1'b1);
        end
    endtask
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checks++;
        if (g !== e)
        begin
            fails++;
            $display("unexpected at %0t: control %h not %h", $time, g, e);
        end
    endtask
    task automatic chkn(input int g, input int e);
        checks++;
        if (g != e)
        begin
            fails++;
            $display("unexpected at %0t: count %0d not %0d", $time, g, e);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        forever #20 mclk_in = ~mclk_in;
    end
    initial
    begin
        #100us;
        fails++;
        tally_and_finish();
    end
    initial
    begin
        repeat (3) @(posedge mclk_in);
        #1;
        rst_in = 1'b0;
        idle();
        chk8(ctl, 8'h10);
        foreach (rows[i])
        begin
            if (rows[i].u)
                w(8'h01);
            w(rows[i].d);
            idle();
            chk8(ctl, rows[i].e);
            run(20);
            chkn(nreq + nirq, 0);
        end
        $display("test rows done");
        w(8'h01);
        wr = 1'b0;
        ret = 1'b1;
        @(posedge mclk_in);
        #1;
        ret = 1'b0;
        w(8'h32);
        idle();
        chk8(ctl, 8'h00);
        w(8'h01);
        w(8'h82);
        wr = 1'b0;
        run(10);
        chkn(nreq, 1);
        chk8(ctl, 8'h84);
        w(8'h01);
        w(8'h80);
        idle();
        chk8(ctl, 8'h80);
        sel = 1'b1;
        w(8'h01);
        w(8'h82);
        wr = 1'b0;
        run(10);
        chkn(int'(nirq > 0) + nreq, 1);
        chk8(ctl, 8'h86);
        rst_in = 1'b1;
        idle();
        rst_in = 1'b0;
        idle();
        chk8(ctl, 8'h10);
        $display("test timeouts done");
        tally_and_finish();
    end
endmodule
